// ### hw/rfts_pkg.sv
// Purpose: Shared constants and types of the report frame sequencer
// Assumes: 250 MHz system clock, 0.5 MHz line bit rate derived from it
// Notes:   All register offsets, field positions and counts live here
package rfts_pkg;

  // Clock and line rate
  localparam int CLK_PERIOD_NS = 4;                           // System clock period
  localparam int TX_BIT_NS     = 2000;                        // One line bit period
  localparam int TX_DIV_CYC    = TX_BIT_NS / CLK_PERIOD_NS;   // Clocks per line bit
  localparam int DIV_W         = 9;                           // Divider counter width
  localparam logic [DIV_W-1:0] TX_DIV_LAST = DIV_W'(TX_DIV_CYC - 1);
  localparam logic [DIV_W-1:0] TX_DIV_HALF = DIV_W'(TX_DIV_CYC / 2);

  // Data path sizes
  localparam int WORD_W    = 16;                              // Buffered word width
  localparam int BUF_DEPTH = 16;                              // Input buffer words
  localparam int IDX_W     = 4;                               // Buffer index width
  localparam int PTR_W     = 5;                               // Pointer with wrap bit
  localparam int FRAME_W   = 8;                               // Idle frame length
  localparam logic [PTR_W-1:0] PTR_ONE  = 5'h01;
  localparam logic [PTR_W-1:0] BUF_FULL = 5'h10;              // Words held when full

  // Sequencing counts
  localparam logic [3:0] BIT_LAST   = 4'hF;                   // Last bit of a word
  localparam logic [2:0] ABORT_LAST = 3'h7;                   // Eighth abort one
  localparam logic [2:0] WIN_LOCK   = 3'h1;                   // Window phase after lock
  localparam logic [2:0] WIN_OPEN   = 3'h0;                   // Window phase of strobe
  localparam logic [2:0] STUFF_LAST = 3'h4;                   // Fifth one in a run

  // Check sequence
  localparam logic [WORD_W-1:0] CRC_POLY = 16'h1021;          // x^16+x^12+x^5+1
  localparam logic [WORD_W-1:0] CRC_INIT = 16'h0000;

  // APB register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;           // Write: GO command
  localparam logic [ADDR_W-1:0] REG_IDLE   = 8'h04;           // Idle frame pattern
  localparam logic [ADDR_W-1:0] REG_DATA   = 8'h08;           // Input buffer push
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;           // Controller status
  localparam logic [7:0] IDLE_RESET = 8'h7E;                  // Idle pattern at reset

  // Field positions
  localparam int CTRL_GO     = 0;
  localparam int STAT_STATE  = 0;                             // Three bits
  localparam int STAT_SYNC   = 3;
  localparam int STAT_CYCLE  = 4;
  localparam int STAT_RUN    = 5;
  localparam int STAT_GO     = 6;
  localparam int STAT_ARM    = 7;
  localparam int STAT_COUNT  = 8;                             // Five bits

  // Controller states
  typedef enum logic [2:0] {
    ST_INIT, ST_ABORT, ST_IDLE, ST_DATA, ST_LAST, ST_CHECK
  } rfts_state_t;

endpackage

// ### hw/rfts_tx_if.sv
// Purpose: Bit stream signals between the sequencer and its helpers
// Assumes: One clock; ticks are one-cycle enables
// Notes:   ctl_tick is the gated transmission tick
interface rfts_tx_if (
  input wire logic clk,
  input wire logic reset
);
  logic tx_tick;      // Free running line bit tick
  logic ctl_tick;     // Line tick minus stuffed zeros
  logic msg_sel;      // Message/idle select, enables stuffing
  logic stuff_din;    // Bit offered to the line
  logic line_bit;     // Registered line bit
  logic fcs_start;    // Preset the check register
  logic fcs_feed;     // Feed payload bits
  logic fcs_emit;     // Shift check bits out
  logic fcs_din;      // Payload bit into the check register
  logic fcs_bit;      // Current check bit

  modport ctl (input clk, reset, ctl_tick, line_bit, fcs_bit,
               output tx_tick, msg_sel, stuff_din, fcs_start, fcs_feed, fcs_emit, fcs_din);
  modport stuff (input clk, reset, tx_tick, msg_sel, stuff_din,
                 output ctl_tick, line_bit);
  modport fcs (input clk, reset, ctl_tick, fcs_start, fcs_feed, fcs_emit, fcs_din,
               output fcs_bit);
endinterface

// ### hw/rfts_zero_insert.sv
// Purpose: Zero-bit insertion and line bit register
// Assumes: Ticks from the sequencer's divider
// Notes:   A stuffed zero withholds one gated tick
module rfts_zero_insert
  import rfts_pkg::*;
(
  rfts_tx_if.stuff tx
);
  logic [2:0] run_q;    // Consecutive ones seen
  logic       skip_q;   // Zero owed on the next tick
  logic       line_q;   // Bit on the line

  // Gate the control tick while a zero is stuffed
  assign tx.ctl_tick = tx.tx_tick & ~skip_q;
  assign tx.line_bit = line_q;

  always_ff @(posedge tx.clk) begin
    if (tx.reset) begin
      run_q  <= 3'h0;
      skip_q <= 1'b0;
      line_q <= 1'b1;
    end else if (tx.tx_tick) begin
      if (skip_q) begin
        // Inserted zero, count starts over
        line_q <= 1'b0;
        skip_q <= 1'b0;
        run_q  <= 3'h0;
      end else begin
        line_q <= tx.stuff_din;
        if (tx.msg_sel && tx.stuff_din) begin
          if (run_q == STUFF_LAST) begin
            skip_q <= 1'b1;
            run_q  <= 3'h0;
          end else begin
            run_q <= run_q + 3'h1;
          end
        end else begin
          // Zero bit or idle traffic clears the run
          run_q <= 3'h0;
        end
      end
    end
  end

  chk_stall_on_skip: assert property (
    @(posedge tx.clk) disable iff (tx.reset) skip_q |-> !tx.ctl_tick)
    else $error("gated tick ran during a stuffed zero");
  chk_zero_after_five: assert property (
    @(posedge tx.clk) disable iff (tx.reset) (skip_q && tx.tx_tick) |=> (line_q == 1'b0))
    else $error("stuffed bit was not zero");
endmodule

// ### hw/rfts_fcs_gen.sv
// Purpose: Serial 16-bit frame check generator
// Assumes: Most significant bit first
// Notes:   Advances on the gated tick only
module rfts_fcs_gen
  import rfts_pkg::*;
(
  rfts_tx_if.fcs fx
);
  logic [WORD_W-1:0] crc_q;   // Remainder register
  logic              fb;      // Feedback bit

  assign fb        = crc_q[WORD_W-1] ^ fx.fcs_din;
  assign fx.fcs_bit = crc_q[WORD_W-1];

  always_ff @(posedge fx.clk) begin
    if (fx.reset) begin
      crc_q <= CRC_INIT;
    end else if (fx.ctl_tick) begin
      if (fx.fcs_start) begin
        crc_q <= CRC_INIT;
      end else if (fx.fcs_feed) begin
        crc_q <= {crc_q[WORD_W-2:0], 1'b0} ^ ({WORD_W{fb}} & CRC_POLY);
      end else if (fx.fcs_emit) begin
        // Check bits leave from the top
        crc_q <= {crc_q[WORD_W-2:0], 1'b0};
      end
    end
  end
endmodule

// ### hw/rfts_sequencer.sv
// Purpose: Inserts buffered reports between looping idle frames
// Assumes: APB3 slave with zero wait states; one 250 MHz clock
// Notes:   Line timing is an enable from a divider, not a clock
//
// Functional notes
// - report-ready flag tracks buffered report
// - idle-lock flag follows frame alignment
// - equal pointers mean empty, then append check
// - reset zeros pointers, flags, state zero
// - initial state sends ones, window open
// - locked window pulse every eight ticks
// - abort state sends at least eight ones
// - end abort, send idle, wait
// - latch GO pulse; arm when ready
// - both latches plus strobe start data
// - data entry loads word, starts check
// - every sixteen ticks load next word
// - last word enters state four
// - check state sends sixteen check bits
// - completion clears latches, back to idle
// - lost alignment resets buffer and state
// - controller runs on gated tick
// - stuff zero after five ones
// - idle strobe marks each frame start
// - check polynomial x16+x12+x5+1
//
// Chosen here: the APB register port and the address map.
module rfts_sequencer
  import rfts_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   line_data,
  output logic                   line_clk,
  output logic                   idle_lock
);

  rfts_tx_if tx (.clk(clk), .reset(reset));

  rfts_zero_insert u_stuff (.tx(tx));
  rfts_fcs_gen     u_fcs   (.fx(tx));

  // Address decode used by the setup-phase error check
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_IDLE) || (a == REG_DATA) || (a == REG_STATUS);
  endfunction

  // Last-word test used at every word load
  function automatic logic is_last(input logic [PTR_W-1:0] rd, input logic [PTR_W-1:0] wr);
    return (rd + PTR_ONE) == wr;
  endfunction

  logic [DIV_W-1:0]  div_q;           // Line bit divider
  logic              tick_q;          // One-cycle line tick
  logic              lclk_q;          // Line clock out
  rfts_state_t       state_q;         // Controller state
  logic              sync_q;          // Idle-lock flag
  logic              cycle_q;         // Abort-done flag
  logic              run_q;           // Report-ready flag
  logic              go_q;            // Load-complete latch
  logic              arm_q;           // Arm latch
  logic [2:0]        win_q;           // Window phase
  logic [2:0]        abort_q;         // Abort ones sent
  logic [3:0]        bit_q;           // Bit within word or check
  logic [WORD_W-1:0] sh_q;            // Word shift register
  logic [PTR_W-1:0]  rd_q;            // Buffer read pointer
  logic [PTR_W-1:0]  wr_q;            // Buffer write pointer
  logic [FRAME_W-1:0] idle_pat_q;     // Idle frame pattern
  logic [FRAME_W-1:0] idle_sr_q;      // Looping idle frame
  logic [WORD_W-1:0] buf_mem [BUF_DEPTH];  // Input buffer
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              lock_q;

  logic ctl_tick;       // Gated transmission tick
  logic idle_strobe;    // Start of idle frame
  logic sync_win;       // Lock window
  logic lost;           // Alignment lost this tick
  logic clr;            // Hardware reset or lost alignment
  logic buf_empty;
  logic buf_full;
  logic start_ok;       // Report may begin
  logic completion;     // Completion strobe
  logic end_abort;      // End-abort strobe
  logic arm_strobe;     // Arm strobe
  logic go_wr;          // GO command written
  logic apb_wr;         // Write taken this edge
  logic [PTR_W-1:0] count;
  logic abort_select;
  logic payload_check_select;
  logic message_idle_select;

  assign ctl_tick = tx.ctl_tick;
  assign count    = wr_q - rd_q;

  assign buf_empty = (rd_q == wr_q);
  assign buf_full  = (count == BUF_FULL);

  assign idle_strobe = (idle_sr_q == idle_pat_q);

  // window held open until locked; one tick in eight after
  assign sync_win = (state_q == ST_INIT) || (win_q == WIN_OPEN);

  assign lost = sync_q && ctl_tick && sync_win && !idle_strobe;
  assign clr  = reset || lost;

  assign start_ok   = go_q && arm_q && idle_strobe && !buf_empty;
  assign completion = ctl_tick && (state_q == ST_CHECK) && (bit_q == BIT_LAST);
  assign end_abort  = ctl_tick && (state_q == ST_ABORT) && (abort_q == ABORT_LAST);
  assign arm_strobe = (state_q == ST_IDLE) && cycle_q;

  assign apb_wr = psel && penable && pready_q && pwrite;
  assign go_wr  = apb_wr && (paddr == REG_CTRL) && pwdata[CTRL_GO];

  // Stream selects
  assign abort_select         = (state_q == ST_INIT) || (state_q == ST_ABORT);
  assign payload_check_select = (state_q != ST_CHECK);
  assign message_idle_select  = (state_q == ST_DATA) || (state_q == ST_LAST) ||
                                (state_q == ST_CHECK);

  // Line bit source mux
  always_comb begin
    if (abort_select) begin
      tx.stuff_din = 1'b1;
    end else if (!message_idle_select) begin
      tx.stuff_din = idle_sr_q[FRAME_W-1];
    end else if (payload_check_select) begin
      tx.stuff_din = sh_q[WORD_W-1];
    end else begin
      tx.stuff_din = tx.fcs_bit;
    end
  end

  assign tx.msg_sel   = message_idle_select;
  assign tx.tx_tick   = tick_q;
  assign tx.fcs_start = (state_q == ST_IDLE);
  assign tx.fcs_feed  = (state_q == ST_DATA) || (state_q == ST_LAST);
  assign tx.fcs_emit  = (state_q == ST_CHECK);
  assign tx.fcs_din   = sh_q[WORD_W-1];

  // Line bit divider and clock out; runs through stuffed zeros
  always_ff @(posedge clk) begin
    if (reset) begin
      div_q  <= '0;
      tick_q <= 1'b0;
      lclk_q <= 1'b0;
    end else begin
      div_q  <= (div_q == TX_DIV_LAST) ? '0 : div_q + 1'b1;
      tick_q <= (div_q == TX_DIV_LAST);
      lclk_q <= (div_q >= TX_DIV_HALF);
    end
  end

  // Idle frame loop; a pattern write reloads it
  always_ff @(posedge clk) begin
    if (reset) begin
      idle_pat_q <= IDLE_RESET;
      idle_sr_q  <= IDLE_RESET;
    end else if (apb_wr && (paddr == REG_IDLE)) begin
      idle_pat_q <= pwdata[FRAME_W-1:0];
      idle_sr_q  <= pwdata[FRAME_W-1:0];
    end else if (ctl_tick) begin
      idle_sr_q <= {idle_sr_q[FRAME_W-2:0], idle_sr_q[FRAME_W-1]};
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      sync_q <= 1'b0;
      win_q  <= WIN_OPEN;
    end else if (ctl_tick) begin
      if (state_q == ST_INIT && idle_strobe) begin
        sync_q <= 1'b1;
        win_q  <= WIN_LOCK;
      end else begin
        win_q <= win_q + 3'h1;
      end
    end
  end

  // GO latch, set wins over clear
  always_ff @(posedge clk) begin
    if (go_wr) begin
      go_q <= 1'b1;
    end else if (clr || completion) begin
      go_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      arm_q <= 1'b0;
    end else if (arm_strobe) begin
      arm_q <= 1'b1;
    end else if (completion) begin
      arm_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      cycle_q <= 1'b0;
    end else if (end_abort) begin
      cycle_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      run_q <= 1'b0;
    end else if (ctl_tick && state_q == ST_IDLE && start_ok) begin
      run_q <= 1'b1;
    end else if (completion) begin
      run_q <= 1'b0;
    end
  end

  // controller state on gated tick only
  always_ff @(posedge clk) begin
    if (clr) begin
      state_q <= ST_INIT;
      abort_q <= 3'h0;
      bit_q   <= 4'h0;
    end else if (ctl_tick) begin
      unique case (state_q)
        ST_INIT: begin
          if (idle_strobe) begin
            state_q <= ST_ABORT;
            abort_q <= 3'h0;
          end
        end
        ST_ABORT: begin
          abort_q <= abort_q + 3'h1;
          if (abort_q == ABORT_LAST) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          // start on strobe; single word goes straight to last
          if (start_ok) begin
            state_q <= is_last(rd_q, wr_q) ? ST_LAST : ST_DATA;
            bit_q   <= 4'h0;
          end
        end
        ST_DATA: begin
          bit_q <= bit_q + 4'h1;
          // word boundary; last word moves to state four
          if (bit_q == BIT_LAST) begin
            state_q <= is_last(rd_q, wr_q) ? ST_LAST : ST_DATA;
          end
        end
        ST_LAST: begin
          bit_q <= bit_q + 4'h1;
          if (bit_q == BIT_LAST) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          bit_q <= bit_q + 4'h1;
          if (bit_q == BIT_LAST) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Word shift register and read pointer
  always_ff @(posedge clk) begin
    if (clr) begin
      rd_q <= '0;
      sh_q <= '0;
    end else if (ctl_tick) begin
      if ((state_q == ST_IDLE && start_ok) ||
          (state_q == ST_DATA && bit_q == BIT_LAST)) begin
        sh_q <= buf_mem[rd_q[IDX_W-1:0]];
        rd_q <= rd_q + PTR_ONE;
      end else if (state_q == ST_DATA || state_q == ST_LAST) begin
        sh_q <= {sh_q[WORD_W-2:0], 1'b0};
      end
    end
  end

  // Buffer writes from the bus; full buffer refuses
  always_ff @(posedge clk) begin
    if (clr) begin
      wr_q <= '0;
    end else if (apb_wr && paddr == REG_DATA && !buf_full) begin
      wr_q <= wr_q + PTR_ONE;
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (apb_wr && paddr == REG_DATA && !buf_full) begin
      buf_mem[wr_q[IDX_W-1:0]] <= pwdata[WORD_W-1:0];
    end
  end

  // APB answer prepared in the setup cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable &&
                   (!is_mapped(paddr) || (pwrite && paddr == REG_DATA && buf_full));
      prdata_q  <= '0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          REG_IDLE: prdata_q[FRAME_W-1:0] <= idle_pat_q;
          REG_STATUS: begin
            prdata_q[STAT_STATE +: 3]     <= state_q;
            prdata_q[STAT_SYNC]           <= sync_q;
            prdata_q[STAT_CYCLE]          <= cycle_q;
            prdata_q[STAT_RUN]            <= run_q;
            prdata_q[STAT_GO]             <= go_q;
            prdata_q[STAT_ARM]            <= arm_q;
            prdata_q[STAT_COUNT +: PTR_W] <= count;
          end
          default: prdata_q <= '0;
        endcase
      end
    end
  end

  // Status pin register
  always_ff @(posedge clk) begin
    if (clr) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= sync_q;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign line_data = tx.line_bit;
  assign line_clk  = lclk_q;
  assign idle_lock = lock_q;

  chk_reset_state: assert property (
    @(posedge clk) reset |=> (state_q == ST_INIT && !sync_q && !cycle_q && !run_q &&
                              rd_q == '0 && wr_q == '0))
    else $error("reset left controller state");
  chk_init_ones: assert property (
    @(posedge clk) disable iff (reset) (state_q == ST_INIT || state_q == ST_ABORT)
      |-> (tx.stuff_din && !message_idle_select))
    else $error("ones not selected before abort end");
  chk_window_loss: assert property (
    @(posedge clk) disable iff (reset)
      (sync_q && ctl_tick && sync_win && !idle_strobe) |=> (!sync_q && state_q == ST_INIT))
    else $error("missed strobe did not drop lock");
  chk_abort_end: assert property (
    @(posedge clk) disable iff (reset)
      (state_q == ST_ABORT) ##1 (state_q == ST_IDLE) |-> (cycle_q && $past(abort_q) == ABORT_LAST))
    else $error("abort ended early or flag not set");
  chk_run_entry: assert property (
    @(posedge clk) disable iff (reset)
      (state_q == ST_IDLE && ctl_tick && start_ok && !lost)
      |=> (run_q && (state_q == ST_DATA || state_q == ST_LAST)))
    else $error("report start not taken");
  chk_word_hold: assert property (
    @(posedge clk) disable iff (reset)
      (state_q == ST_DATA && ctl_tick && bit_q != BIT_LAST && !lost) |=> (state_q == ST_DATA))
    else $error("data state left mid word");
  chk_check_route: assert property (
    @(posedge clk) disable iff (reset)
      (state_q == ST_CHECK) |-> (!payload_check_select && tx.stuff_din == tx.fcs_bit))
    else $error("check bits not routed");
  chk_completion_clear: assert property (
    @(posedge clk) disable iff (reset)
      (completion && !lost && !go_wr) |=> (state_q == ST_IDLE && !run_q && !go_q && !arm_q))
    else $error("completion did not clear flags");
  chk_go_set_wins: assert property (
    @(posedge clk) disable iff (reset) go_wr |=> go_q)
    else $error("GO write lost");
endmodule

// ### tb/rfts_line_rx.sv
// Purpose: Far-side line receiver model, records the raw serial stream
// Assumes: A bit is sampled at each rising line clock, mid bit
// Notes:   No zero removal; the bench judges stuffing on raw bits
module rfts_line_rx (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         line_clk,
  input  wire logic         line_data,
  output logic      [127:0] hist_q,
  output logic      [7:0]   run_max_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_d_q;  // Line clock one system clock ago
  logic [7:0] run_q;    // Length of the current run of ones

  // Shift in on the rising line clock, where the bit has long settled
  always_ff @(posedge clk) begin
    clk_d_q <= line_clk;
    if (reset) begin
      hist_q    <= 128'h0;
      run_q     <= 8'h00;
      run_max_q <= 8'h00;
    end else if (line_clk && !clk_d_q) begin
      hist_q <= {hist_q[126:0], line_data};
      run_q  <= line_data ? run_q + 8'h01 : 8'h00;
      // Longest run of ones, for the abort length
      if (line_data && run_q >= run_max_q) begin
        run_max_q <= run_q + 8'h01;
      end
    end
  end
endmodule

// ### tb/tb_top.sv
// Purpose: Self-checking bench of the report frame sequencer
// Assumes: Zero wait APB slave, line bit every 500 clocks
// Notes:   Loss of lock is provoked by reloading the idle loop off phase
module tb_top
  import rfts_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0, reset = 1'b1;  // Clock, reset held at start
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0, prdata, rd;  // rd: last read data
  logic              pready, pslverr, er, line_data, line_clk, idle_lock;
  logic [127:0]      hist;                        // Raw received bits, newest at 0
  logic [7:0]        run_max;                     // Longest ones run seen
  logic              exp_q[$];                    // Expected stuffed frame bits
  int                err_total = 0, comparisons = 0;

  always #2 clk = ~clk;

  rfts_sequencer dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_data(line_data), .line_clk(line_clk), .idle_lock(idle_lock));
  rfts_line_rx rx_u (.clk(clk), .reset(reset), .line_clk(line_clk), .line_data(line_data),
    .hist_q(hist), .run_max_q(run_max));

  task summarize;
    $display("Mismatches %0d of %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // One APB transfer; entered right after a rising edge, leaves one idle cycle
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      chk(32'h0, 32'h1, "no ready");
      summarize();
    end
  endtask

  // Poll status until the state field matches, bounded
  task wait_st(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[2:0] !== s && n < 20000);
    if (n >= 20000) begin
      chk(32'h0, 32'h1, "state hang");
      summarize();
    end
  endtask

  // Reset values, the line at reset, the idle pattern and a refused address
  task t_regs;
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0, "status at reset");
    chk({31'h0, line_data}, 32'h1, "ones before lock");
    apb(1'b0, REG_IDLE, 32'h0);
    chk(rd, 32'h0000_007E, "idle pattern");
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], er}, 32'h1, "unmapped");
  endtask

  // Fill until refused, then reset must empty the buffer
  task t_full;
    for (int i = 0; i < 16; i++) apb(1'b1, REG_DATA, 32'h0000_0100 + i);
    apb(1'b1, REG_DATA, 32'h0000_FFFF);
    chk({31'h0, er}, 32'h1, "full refuse");
    apb(1'b0, REG_STATUS, 32'h0);
    chk({27'h0, rd[12:8]}, 32'h10, "count full");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0, "cleared by reset");
  endtask

  // Lock, abort ones, then looping idle frames
  task t_lock;
    wait_st(ST_IDLE);
    // Arm latch follows the state by one clock, so read status once more
    apb(1'b0, REG_STATUS, 32'h0);
    chk({29'h0, idle_lock, rd[STAT_CYCLE], rd[STAT_ARM]}, 32'h7, "locked idle");
    chk({31'h0, run_max >= 8'h08}, 32'h1, "abort run");
    repeat (10000) @(posedge clk);
    chk({31'h0, hist[15:8] === hist[7:0] && $countones(hist[7:0]) == 6}, 32'h1, "idle");
  endtask

  // Two-word report: sequence of states, flags and the bits on the line
  task t_msg;
    logic [47:0] f;
    logic [15:0] c;
    int          ones, hit, ok, n;
    apb(1'b1, REG_DATA, 32'h0000_F800);
    apb(1'b1, REG_DATA, 32'h0000_1234);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({26'h0, rd[12:8], rd[STAT_RUN]}, 32'h4, "loaded, idle");
    apb(1'b1, REG_CTRL, 32'h1);
    wait_st(ST_LAST);
    chk({25'h0, rd[12:8], rd[STAT_GO], rd[STAT_RUN]}, 32'h3, "running");
    wait_st(ST_CHECK);
    wait_st(ST_IDLE);
    chk({25'h0, rd[12:8], rd[STAT_GO], rd[STAT_RUN]}, 32'h0, "done");
    repeat (4000) @(posedge clk);
    // Expected frame: words, check bits, a zero after five ones
    f = {32'hF800_1234, 16'h0000};
    c = 16'h0000;
    for (int i = 47; i >= 16; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ f[i]) ? 16'h1021 : 16'h0);
    f[15:0] = c;
    ones = 0;
    for (int i = 47; i >= 0; i--) begin
      exp_q.push_back(f[i]);
      ones = f[i] ? ones + 1 : 0;
      if (ones == 5) begin
        exp_q.push_back(1'b0);
        ones = 0;
      end
    end
    n = exp_q.size();
    hit = 0;
    for (int k = 0; k + n <= 128; k++) begin
      ok = 1;
      for (int i = 0; i < n; i++) if (hist[k + n - 1 - i] !== exp_q[i]) ok = 0;
      if (ok == 1) hit = 1;
    end
    chk(32'(hit), 32'h1, "frame bits");
  endtask

  // Reload the idle loop until a window tick misses; lock and buffer drop
  task t_loss;
    int n;
    apb(1'b1, REG_DATA, 32'h0000_5555);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({27'h0, rd[12:8]}, 32'h1, "one word held");
    n = 0;
    do begin
      // A fresh reload every ten line bits shifts the strobe phase
      if (n % 1700 == 0) apb(1'b1, REG_IDLE, 32'h0000_007E);
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[2:0] !== 3'h0 && n < 5100);
    chk({23'h0, rd[12:8], rd[STAT_SYNC], rd[2:0]}, 32'h0, "lock loss reset");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_full();
    t_lock();
    t_msg();
    t_loss();
    summarize();
  end
endmodule
